/* inc/pgms_pkg.sv */
// Purpose: shared constants and types of the power-good / mode status block
// Assumes: 40 MHz block clock
// Notes:   timing counts are derived from the printed times, rounded up
package pgms_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int HOLDOFF_US    = 20;
  localparam int STARTUP_MS    = 5;
  localparam int HOLDOFF_CYC   = (HOLDOFF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CYC   = (STARTUP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic       CLOCK_GATE_ENABLE_N_N_RST = 1'h1;
  localparam logic       PGOOD_OEN_RST = 1'h0;
  localparam logic       DRV_SKIP_RST = 1'h0;
  localparam logic [4:0] PINS_RST = 5'h00;

  typedef enum logic [5:0] {
    ST_SHUTDOWN  = 6'h01,
    ST_SOFTSTART = 6'h02,
    ST_BOOT      = 6'h04,
    ST_BOOT_VID  = 6'h08,
    ST_RUN       = 6'h10,
    ST_SOFTSTOP  = 6'h20
  } pgms_state_e;

  typedef enum logic [1:0] {
    MODE_1PH_SKIP = 2'h0,
    MODE_NM1_PWM  = 2'h1,
    MODE_N_PWM    = 2'h2,
    MODE_N_SKIP   = 2'h3
  } pgms_mode_e;

  localparam pgms_mode_e MODE_RST = MODE_N_SKIP;

  typedef struct packed {
    logic enable;
    logic deeperSleep;
    logic powerState;
    logic aboveUpper;
    logic belowLower;
  } pgms_pins_s;

endpackage : pgms_pkg

/* rtl/pgms_timer.sv */
// Purpose: one-shot delay counter, busy for CYCLES clock cycles after start
// Assumes: start is a one-cycle pulse on sys_clk
// Notes:   a start while busy restarts the count
`timescale 1ns/100ps
`default_nettype none
module pgms_timer #(
  parameter int CYCLES = 800
) (
  input  wire logic sys_clk, // block clock
  input  wire logic rst_n,   // synchronous reset, active low
  input  wire logic start,   // begin the delay
  output var  logic busy     // high while counting
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES - 1);

  logic [W-1:0] cnt_r, cnt_nxt;
  logic         busy_r, busy_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    if (start) begin
      cnt_nxt  = LOAD;
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      if (cnt_r == '0) begin
        busy_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy = busy_r;
endmodule : pgms_timer
`default_nettype wire

/* rtl/pgms_top.sv */
// Purpose: operating-mode decode and clock-enable / power-good / driver-skip sequencing
// Assumes: comparator and pin inputs are asynchronous; sequencer events are on sys_clk
// Notes:   reset is the shutdown state; open-drain pin as out plus active-low enable
`timescale 1ns/100ps
`default_nettype none
module pgms_top #(
  parameter int HOLDOFF_CYC = pgms_pkg::HOLDOFF_CYC,
  parameter int STARTUP_CYC = pgms_pkg::STARTUP_CYC
) (
  input  wire logic           sys_clk,                  // 40 MHz block clock
  input  wire logic           rst_n,                    // synchronous reset, active low
  input  wire logic           enable,                   // regulator enable pin
  input  wire logic           deeperSleepRequest,       // sleep request pin
  input  wire logic           powerStateIndicator,      // power-state pin
  input  wire logic           feedbackSenseAboveUpper,  // feedback above upper threshold
  input  wire logic           feedbackSenseBelowLower,  // feedback below lower threshold
  input  wire logic           softStartDone,            // pulse: output reached boot voltage
  input  wire logic           softStopDone,             // pulse: soft-shutdown ramp finished
  input  wire logic           slewActive,               // slew controller ramping
  input  wire logic           slewDown,                 // ramp direction is downward
  output var  logic           clockGateEnableN,         // clock enable, active low
  output var  logic           outputRegulationGoodOut,  // power-good output level
  output var  logic           outputRegulationGoodOeN,  // power-good drive enable, active low
  output var  logic           externalDriverSkipCtrl,   // high forced PWM, low skip
  output var pgms_pkg::pgms_mode_e phaseMode            // decoded phase/skip mode
);

  // pin synchroniser: three stages, a change counts once stages two and three agree
  pgms_pkg::pgms_pins_s pinsRaw, syncA_r, syncB_r, syncC_r, pins_r, pins_nxt;

  assign pinsRaw = '{enable: enable, deeperSleep: deeperSleepRequest,
                     powerState: powerStateIndicator, aboveUpper: feedbackSenseAboveUpper,
                     belowLower: feedbackSenseBelowLower};

  always_comb begin
    pins_nxt = pins_r;
    if (syncB_r == syncC_r) begin
      pins_nxt = syncC_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      syncA_r <= pgms_pkg::PINS_RST;
      syncB_r <= pgms_pkg::PINS_RST;
      syncC_r <= pgms_pkg::PINS_RST;
      pins_r  <= pgms_pkg::PINS_RST;
    end else begin
      syncA_r <= pinsRaw;
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
      pins_r  <= pins_nxt;
    end
  end

  // sequencing state
  pgms_pkg::pgms_state_e state_r, state_nxt;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pgms_pkg::ST_SHUTDOWN: begin
        if (pins_r.enable) state_nxt = pgms_pkg::ST_SOFTSTART;
      end
      pgms_pkg::ST_SOFTSTART: begin
        if (!pins_r.enable) state_nxt = pgms_pkg::ST_SOFTSTOP;
        else if (softStartDone) state_nxt = pgms_pkg::ST_BOOT;
      end
      pgms_pkg::ST_BOOT: begin
        if (!pins_r.enable) state_nxt = pgms_pkg::ST_SOFTSTOP;
        else if (slewActive) state_nxt = pgms_pkg::ST_BOOT_VID;
      end
      pgms_pkg::ST_BOOT_VID: begin
        if (!pins_r.enable) state_nxt = pgms_pkg::ST_SOFTSTOP;
        else if (!slewActive) state_nxt = pgms_pkg::ST_RUN;
      end
      pgms_pkg::ST_RUN: begin
        if (!pins_r.enable) state_nxt = pgms_pkg::ST_SOFTSTOP;
      end
      pgms_pkg::ST_SOFTSTOP: begin
        if (softStopDone) state_nxt = pgms_pkg::ST_SHUTDOWN;
      end
      default: state_nxt = pgms_pkg::ST_SHUTDOWN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) state_r <= pgms_pkg::ST_SHUTDOWN;
    else        state_r <= state_nxt;
  end

  logic inOffPhase;
  assign inOffPhase = (state_r == pgms_pkg::ST_SHUTDOWN) || (state_r == pgms_pkg::ST_SOFTSTART)
                   || (state_r == pgms_pkg::ST_SOFTSTOP);

  // delays; the previous-slew flop bridges the cycle before the hold-off counter is busy
  logic slewPrev_r, slewPrev_nxt, holdBusy, startupBusy, startupStart;
  logic pend_r, pend_nxt;

  assign slewPrev_nxt = slewActive;
  assign startupStart = pend_r && !clockGateEnableN;

  pgms_timer #(.CYCLES(HOLDOFF_CYC)) u_holdoff (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (slewPrev_r && !slewActive),
    .busy    (holdBusy)
  );

  pgms_timer #(.CYCLES(STARTUP_CYC)) u_startup (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (startupStart),
    .busy    (startupBusy)
  );

  logic inTransition, startupHold;
  assign inTransition = slewActive || slewPrev_r || holdBusy;
  assign startupHold  = pend_r || startupBusy;

  // startup delay armed at soft-start, fired by the first low clock-enable
  always_comb begin
    pend_nxt = pend_r;
    if (state_r == pgms_pkg::ST_SOFTSTART) pend_nxt = 1'b1;
    else if (state_r == pgms_pkg::ST_SHUTDOWN) pend_nxt = 1'b0;
    else if (startupStart) pend_nxt = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      slewPrev_r <= 1'b0;
      pend_r     <= 1'b0;
    end else begin
      slewPrev_r <= slewPrev_nxt;
      pend_r     <= pend_nxt;
    end
  end

  // upper-threshold blanking: one flag serves both outputs so they stay complementary outside the startup hold (startupHold)
  logic blank_r, blank_nxt, inReg;

  always_comb begin
    blank_nxt = blank_r;
    if (slewActive && slewDown && !externalDriverSkipCtrl) begin
      blank_nxt = 1'b1;
    end else if (!inTransition && !pins_r.aboveUpper && !pins_r.belowLower) begin
      blank_nxt = 1'b0;
    end
    if (inOffPhase) blank_nxt = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) blank_r <= 1'b0;
    else        blank_r <= blank_nxt;
  end

  assign inReg = !pins_r.belowLower && (!pins_r.aboveUpper || blank_r);

  // mode decode
  pgms_pkg::pgms_mode_e mode_r, mode_nxt;
  logic clkEnN_r, clkEnN_nxt, pgOeN_r, pgOeN_nxt, skip_r, skip_nxt, pgOut_r;

  always_comb begin
    unique case (state_r)
      pgms_pkg::ST_SHUTDOWN, pgms_pkg::ST_SOFTSTART, pgms_pkg::ST_BOOT:
        mode_nxt = pgms_pkg::MODE_N_SKIP;
      pgms_pkg::ST_BOOT_VID, pgms_pkg::ST_SOFTSTOP:
        mode_nxt = pgms_pkg::MODE_N_PWM;
      default: begin
        if (pins_r.deeperSleep) mode_nxt = pgms_pkg::MODE_1PH_SKIP;
        else if (!pins_r.powerState) mode_nxt = pgms_pkg::MODE_NM1_PWM;
        else mode_nxt = pgms_pkg::MODE_N_PWM;
      end
    endcase
  end

  // outputs
  always_comb begin
    if (inOffPhase) clkEnN_nxt = 1'b1;
    else if (inTransition) clkEnN_nxt = 1'b0;
    else clkEnN_nxt = !inReg;

    if (inOffPhase) pgOeN_nxt = 1'b0;
    else if (startupHold) pgOeN_nxt = 1'b0;
    else if (inTransition) pgOeN_nxt = 1'b1;
    else pgOeN_nxt = inReg;

    // drivers shut down once soft-stop ends and shutdown selects skip
    skip_nxt = (mode_nxt == pgms_pkg::MODE_N_PWM) || (mode_nxt == pgms_pkg::MODE_NM1_PWM);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode_r   <= pgms_pkg::MODE_RST;
      clkEnN_r <= pgms_pkg::CLOCK_GATE_ENABLE_N_N_RST;
      pgOeN_r  <= pgms_pkg::PGOOD_OEN_RST;
      skip_r   <= pgms_pkg::DRV_SKIP_RST;
      pgOut_r  <= 1'b0;
    end else begin
      mode_r   <= mode_nxt;
      clkEnN_r <= clkEnN_nxt;
      pgOeN_r  <= pgOeN_nxt;
      skip_r   <= skip_nxt;
      pgOut_r  <= 1'b0;
    end
  end

  assign clockGateEnableN        = clkEnN_r;
  assign outputRegulationGoodOeN = pgOeN_r;
  assign outputRegulationGoodOut = pgOut_r;
  assign externalDriverSkipCtrl  = skip_r;
  assign phaseMode               = mode_r;

  property p_sleep_mode;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_r == pgms_pkg::ST_RUN && pins_r.deeperSleep) |=> (mode_r == pgms_pkg::MODE_1PH_SKIP);
  endproperty
  a_sleep_mode: assert property (p_sleep_mode) else $error("sleep did not select 1-phase skip");

  property p_clock_gate_enable_n_off;
    @(posedge sys_clk) disable iff (!rst_n)
    inOffPhase |=> clkEnN_r;
  endproperty
  a_clock_gate_enable_n_off: assert property (p_clock_gate_enable_n_off) else $error("clock enable not high when off");

  property p_clock_gate_enable_n_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_r == pgms_pkg::ST_RUN && $fell(slewActive) && pins_r.enable) ##1 (state_r == pgms_pkg::ST_RUN) [*8]
      |-> !clkEnN_r;
  endproperty
  a_clock_gate_enable_n_hold: assert property (p_clock_gate_enable_n_hold) else $error("clock enable released inside hold-off");

  property p_inverse;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_r == pgms_pkg::ST_RUN && !startupHold && state_nxt == pgms_pkg::ST_RUN) |=> (clkEnN_r == !pgOeN_r);
  endproperty
  a_inverse: assert property (p_inverse) else $error("clock enable not inverse of power-good");

  property p_pg_startup;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_r == pgms_pkg::ST_BOOT && startupHold) |=> !pgOeN_r;
  endproperty
  a_pg_startup: assert property (p_pg_startup) else $error("power-good released during startup delay");

  property p_pg_off;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_r == pgms_pkg::ST_SHUTDOWN || state_r == pgms_pkg::ST_SOFTSTOP) |=> !pgOeN_r;
  endproperty
  a_pg_off: assert property (p_pg_off) else $error("power-good not low in shutdown");

  property p_pg_slew;
    @(posedge sys_clk) disable iff (!rst_n)
    (slewActive && state_r == pgms_pkg::ST_RUN && !startupHold) |=> pgOeN_r;
  endproperty
  a_pg_slew: assert property (p_pg_slew) else $error("power-good driven during ramp");

  property p_skip_end;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_r == pgms_pkg::ST_SOFTSTOP && softStopDone) |=> ##1 !skip_r;
  endproperty
  a_skip_end: assert property (p_skip_end) else $error("driver skip not low after soft-stop");

  property p_boot_mode;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_r == pgms_pkg::ST_SOFTSTART) |=> (mode_r == pgms_pkg::MODE_N_SKIP && !skip_r);
  endproperty
  a_boot_mode: assert property (p_boot_mode) else $error("startup not in N-phase skip");

endmodule : pgms_top
`default_nettype wire

/* verif/pgms_drv_model.sv */
// Purpose: far-side model: external phase drivers and the power-good pull-up
// Assumes: skip control is a push-pull level from the block
// Notes:   drivers are modelled as zero-crossing enable only
`timescale 1ns/100ps
`default_nettype none
module pgms_drv_model (
  input  wire logic skipCtrl,     // driver skip control from the block
  input  wire logic pgOut,        // power-good output data
  input  wire logic pgOeN,        // power-good drive enable, active low
  output var  logic zeroCrossEn,  // drivers skip pulses while high
  output var  logic pgLevel       // resolved power-good wire level
);
  always_comb begin
    // low skip control means pulse skipping, or drivers off after soft-stop
    zeroCrossEn = !skipCtrl;
    // released open-drain line floats up through the pull-up resistor
    pgLevel = pgOeN ? 1'h1 : pgOut;
  end
endmodule : pgms_drv_model
`default_nettype wire

/* verif/tb_pgms_top.sv */
// Purpose: self-checking bench of the power-good / mode status block
// Assumes: short hold-off and startup counts; pins need about 5 cycles to settle
// Notes:   model state 0 shutdown, 1 startup skip, 2 forced full PWM, 3 run
`timescale 1ns/100ps
`default_nettype none
module tb_pgms_top;
  localparam int HOLD  = 8;
  localparam int START = 20;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic enable = 1'h0;
  logic sleep = 1'h0;
  logic power_state_indicator = 1'h0;
  logic above = 1'h0;
  logic below = 1'h0;
  logic ssDone = 1'h0;
  logic spDone = 1'h0;
  logic slew = 1'h0;
  logic slewDn = 1'h0;
  logic clkN, pgOut, pgOeN, skip, zcEn, pgLevel;
  pgms_pkg::pgms_mode_e mode;
  int mismatches = 0;
  int cmpCount = 0;

  pgms_top #(.HOLDOFF_CYC(HOLD), .STARTUP_CYC(START)) pgms_top_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .enable(enable), .deeperSleepRequest(sleep),
    .powerStateIndicator(power_state_indicator), .feedbackSenseAboveUpper(above), .feedbackSenseBelowLower(below),
    .softStartDone(ssDone), .softStopDone(spDone), .slewActive(slew), .slewDown(slewDn),
    .clockGateEnableN(clkN), .outputRegulationGoodOut(pgOut), .outputRegulationGoodOeN(pgOeN),
    .externalDriverSkipCtrl(skip), .phaseMode(mode));

  pgms_drv_model pgms_drv_model_inst (
    .skipCtrl(skip), .pgOut(pgOut), .pgOeN(pgOeN), .zeroCrossEn(zcEn), .pgLevel(pgLevel));

  always #12.5 sys_clk = !sys_clk;

  task automatic stopTest;
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stopTest

  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt

  // model of the mode decode and pin levels; oe is the expected release of power-good
  task automatic chkAll(input int st, input logic ck, input logic oe);
    logic [1:0] m;
    m = (st < 2) ? 2'h3 : (st == 2) ? 2'h2 : sleep ? 2'h0 : power_state_indicator ? 2'h2 : 2'h1;
    chk(mode, m);
    chk({1'h0, skip}, {1'h0, (m == 2'h1 || m == 2'h2)});
    chk({1'h0, zcEn}, {1'h0, !(m == 2'h1 || m == 2'h2)});
    chk({clkN, pgOeN}, {ck, oe});
    chk({pgOut, pgLevel}, {1'h0, oe});
  endtask : chkAll

  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    stopTest();
  end

  initial begin
    void'($urandom(26));
    wt(4);
    rst_n = 1'h1;
    wt(1);
    chkAll(0, 1'h1, 1'h0);
    enable = 1'h1;
    wt(6);
    chkAll(1, 1'h1, 1'h0);
    ssDone = 1'h1;
    wt(1);
    ssDone = 1'h0;
    wt(5);
    chkAll(1, 1'h0, 1'h0);
    slew = 1'h1;
    wt(3);
    chk(mode, 2'h2);
    chk({clkN, skip}, 2'h1);
    slew = 1'h0;
    wt(HOLD + START + 10);
    chkAll(3, 1'h0, 1'h1);
    power_state_indicator = 1'h1;
    above = 1'h1;
    slew = 1'h1;
    // the power-state pin needs the synchroniser plus one edge before the mode follows
    wt(6);
    chkAll(3, 1'h0, 1'h1);
    wt(10);
    slew = 1'h0;
    wt(4);
    chkAll(3, 1'h0, 1'h1);
    wt(HOLD + 2);
    chkAll(3, 1'h1, 1'h0);
    above = 1'h0;
    wt(6);
    chkAll(3, 1'h0, 1'h1);
    sleep = 1'h1;
    wt(6);
    chkAll(3, 1'h0, 1'h1);
    // downward ramp in skip mode with the upper comparator tripped
    slew = 1'h1;
    slewDn = 1'h1;
    above = 1'h1;
    wt(10);
    slew = 1'h0;
    slewDn = 1'h0;
    wt(HOLD + 6);
    chkAll(3, 1'h0, 1'h1);
    above = 1'h0;
    wt(6);
    above = 1'h1;
    wt(6);
    chkAll(3, 1'h1, 1'h0);
    for (int i = 0; i < 12; i++) begin
      {sleep, power_state_indicator, above, below} = 4'($urandom());
      wt(6);
      chkAll(3, above | below, !(above | below));
    end
    above = 1'h0;
    below = 1'h0;
    enable = 1'h0;
    wt(6);
    chkAll(2, 1'h1, 1'h0);
    spDone = 1'h1;
    wt(1);
    spDone = 1'h0;
    wt(3);
    chkAll(0, 1'h1, 1'h0);
    stopTest();
  end
endmodule : tb_pgms_top
`default_nettype wire
